// [hdl/dipc_consts.vh]
// Constants for the dual-input position capture block.
`ifndef DIPC_CONSTS_VH
`define DIPC_CONSTS_VH

// ----------------------------------------------------------------
// Parameter addresses of the fieldbus parameter map
// ----------------------------------------------------------------
`define DIPC_ADDR_W 16
`define DIPC_ADDR_FLAGS 16'h0a02
`define DIPC_ADDR_I1_POS 16'h0a0c
`define DIPC_ADDR_I1_TOTAL 16'h0a10
`define DIPC_ADDR_I2_TOTAL 16'h0a12
`define DIPC_ADDR_I1_TOTAL_SNAP 16'h0a2e
`define DIPC_ADDR_I1_POS_SNAP 16'h0a30
`define DIPC_ADDR_I1_RISE_POS 16'h0a4a
`define DIPC_ADDR_I1_FALL_POS 16'h0a4c
`define DIPC_ADDR_I1_RISE_CNT 16'h0a56
`define DIPC_ADDR_I1_FALL_CNT 16'h0a58
`define DIPC_ADDR_I2_RISE_CNT 16'h0a5a
`define DIPC_ADDR_I2_FALL_CNT 16'h0a5c

// ----------------------------------------------------------------
// Widths, reset values and field positions
// ----------------------------------------------------------------
`define DIPC_CNT_W 16
`define DIPC_POS_W 32
`define DIPC_CNT_RST 16'h0000
`define DIPC_POS_RST 32'h0000_0000
`define DIPC_DATA_RST 32'h0000_0000
`define DIPC_CNT_ONE 16'h0001
`define DIPC_FLAG_I1 0
`define DIPC_FLAG_I2 1
`define DIPC_FLAGS_PAD 14'h0000
`define DIPC_CNT_PAD 16'h0000

// ----------------------------------------------------------------
// Edge selection for the general capture register
// ----------------------------------------------------------------
`define DIPC_EDGE_RISE 2'h0
`define DIPC_EDGE_FALL 2'h1
`define DIPC_EDGE_BOTH 2'h2

`endif

// [hdl/dipc_input_unit.v]
// One capture input: pin synchroniser, edge detection and event counters.
`timescale 1ns/1ps
`include "dipc_consts.vh"

module dipc_input_unit (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Capture pin and control.
	input wire pin,
	input wire enable,
	input wire [1:0] edge_mode,
	// Detected events, same cycle as the counters step.
	output wire activate,
	output wire rise_evt,
	output wire fall_evt,
	output wire capture_evt,
	// Counter values.
	output wire [`DIPC_CNT_W-1:0] rise_cnt,
	output wire [`DIPC_CNT_W-1:0] fall_cnt,
	output wire [`DIPC_CNT_W-1:0] total_cnt
);

	reg meta_ff;
	reg sync_ff;
	reg last_ff;
	reg enable_ff;
	reg [`DIPC_CNT_W-1:0] rise_cnt_ff;
	reg [`DIPC_CNT_W-1:0] fall_cnt_ff;
	reg [`DIPC_CNT_W-1:0] total_cnt_ff;
	reg sel_edge;
	wire [`DIPC_CNT_W-1:0] nxt_rise_cnt;
	wire [`DIPC_CNT_W-1:0] nxt_fall_cnt;
	wire [`DIPC_CNT_W-1:0] nxt_total_cnt;

	// Two flip-flops bring the pin into the clock domain; only sync_ff is looked at.
	always @(posedge clock) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
			enable_ff <= 1'b0;
		end else begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
			enable_ff <= enable;
		end
	end

	// Activation is the rising edge of the enable level.
	assign activate = enable & ~enable_ff;
	// Edges only count while capture is enabled.
	assign rise_evt = enable & sync_ff & ~last_ff;
	assign fall_evt = enable & ~sync_ff & last_ff;

	// The edge mode picks which edges feed the general capture.
	always @* begin
		case (edge_mode)
			`DIPC_EDGE_RISE: sel_edge = rise_evt;
			`DIPC_EDGE_FALL: sel_edge = fall_evt;
			`DIPC_EDGE_BOTH: sel_edge = rise_evt | fall_evt;
			default: sel_edge = rise_evt;
		endcase
	end
	assign capture_evt = sel_edge;

	// An edge in the activation cycle still counts, so it is not lost to the clear.
	assign nxt_rise_cnt = (activate ? `DIPC_CNT_RST : rise_cnt_ff)
		+ (rise_evt ? `DIPC_CNT_ONE : `DIPC_CNT_RST);
	assign nxt_fall_cnt = (activate ? `DIPC_CNT_RST : fall_cnt_ff)
		+ (fall_evt ? `DIPC_CNT_ONE : `DIPC_CNT_RST);
	assign nxt_total_cnt = (activate ? `DIPC_CNT_RST : total_cnt_ff)
		+ (sel_edge ? `DIPC_CNT_ONE : `DIPC_CNT_RST);

	// Counters wrap at the 16-bit limit, as an unsigned count would.
	always @(posedge clock) begin
		if (rst) begin
			rise_cnt_ff <= `DIPC_CNT_RST;
			fall_cnt_ff <= `DIPC_CNT_RST;
			total_cnt_ff <= `DIPC_CNT_RST;
		end else begin
			rise_cnt_ff <= nxt_rise_cnt;
			fall_cnt_ff <= nxt_fall_cnt;
			total_cnt_ff <= nxt_total_cnt;
		end
	end

	assign rise_cnt = rise_cnt_ff;
	assign fall_cnt = fall_cnt_ff;
	assign total_cnt = total_cnt_ff;

endmodule

// [hdl/dipc_capture.v]
// Dual-input position capture: counters, position latches and read port.
// Notes for the next user of this block:
// Counters wrap silently at the 16-bit limit, as an unsigned count does.
// An edge in the activation cycle counts after the clear, so the counter
// reads one there instead of losing that event.
// Capture and origin shift in one cycle: the capture wins, because the
// live position already stands in the new reference.
// The snapshot copy pairs with the count that the same read returns; a
// capture in the read cycle shows in neither half of that pair.
// Only input one keeps positions; input two has counters and a flag.
// Rise and fall counters count every edge while enabled, whatever the mode.
// A pin change reaches the edge compare after two synchroniser stages,
// so a pulse shorter than one clock may be missed.
// Reads of unmapped addresses answer with the error flag and a zero word.
`timescale 1ns/1ps
`include "dipc_consts.vh"

module dipc_capture (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Capture pins.
	input wire capture_pin_one,
	input wire capture_pin_two,
	// Capture control: enable levels and edge selection.
	input wire capture_pin_one_enable,
	input wire capture_pin_two_enable,
	input wire [1:0] capture_pin_one_edge_mode,
	input wire [1:0] capture_pin_two_edge_mode,
	// Actual position and origin change from the position feedback.
	input wire [`DIPC_POS_W-1:0] pos_actual,
	input wire origin_shift_valid,
	input wire [`DIPC_POS_W-1:0] origin_shift,
	// Parameter read port.
	input wire rd_req,
	input wire [`DIPC_ADDR_W-1:0] rd_addr,
	output wire rd_ack,
	output wire rd_err,
	output wire [`DIPC_POS_W-1:0] rd_data
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Recognises every parameter address this block answers.
	function dipc_is_mapped;
		input [`DIPC_ADDR_W-1:0] addr;
		begin
			case (addr)
				`DIPC_ADDR_FLAGS,
				`DIPC_ADDR_I1_POS,
				`DIPC_ADDR_I1_TOTAL,
				`DIPC_ADDR_I2_TOTAL,
				`DIPC_ADDR_I1_TOTAL_SNAP,
				`DIPC_ADDR_I1_POS_SNAP,
				`DIPC_ADDR_I1_RISE_POS,
				`DIPC_ADDR_I1_FALL_POS,
				`DIPC_ADDR_I1_RISE_CNT,
				`DIPC_ADDR_I1_FALL_CNT,
				`DIPC_ADDR_I2_RISE_CNT,
				`DIPC_ADDR_I2_FALL_CNT: dipc_is_mapped = 1'b1;
				default: dipc_is_mapped = 1'b0;
			endcase
		end
	endfunction

	// True when a read addresses the given parameter.
	function dipc_hit;
		input req;
		input [`DIPC_ADDR_W-1:0] addr;
		input [`DIPC_ADDR_W-1:0] target;
		begin
			dipc_hit = req & (addr == target);
		end
	endfunction

	// Widens a counter to the read word, with zero in the upper half.
	function [`DIPC_POS_W-1:0] dipc_cnt_word;
		input [`DIPC_CNT_W-1:0] cnt;
		begin
			dipc_cnt_word = {`DIPC_CNT_PAD, cnt};
		end
	endfunction

	// ----------------------------------------------------------------
	// Per-input edge detection and counters
	// ----------------------------------------------------------------

	wire [1:0] pins;
	wire [1:0] enables;
	wire [3:0] modes;
	wire [1:0] activate;
	wire [1:0] rise_evt;
	wire [1:0] fall_evt;
	wire [1:0] capture_evt;
	wire [2*`DIPC_CNT_W-1:0] rise_cnt;
	wire [2*`DIPC_CNT_W-1:0] fall_cnt;
	wire [2*`DIPC_CNT_W-1:0] total_cnt;

	assign pins = {capture_pin_two, capture_pin_one};
	assign enables = {capture_pin_two_enable, capture_pin_one_enable};
	assign modes = {capture_pin_two_edge_mode, capture_pin_one_edge_mode};

	// Both inputs share one unit design, so they behave identically.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_input
			dipc_input_unit u_unit (
				.clock(clock),
				.rst(rst),
				.pin(pins[gi]),
				.enable(enables[gi]),
				.edge_mode(modes[2*gi+1:2*gi]),
				.activate(activate[gi]),
				.rise_evt(rise_evt[gi]),
				.fall_evt(fall_evt[gi]),
				.capture_evt(capture_evt[gi]),
				.rise_cnt(rise_cnt[`DIPC_CNT_W*gi+`DIPC_CNT_W-1:`DIPC_CNT_W*gi]),
				.fall_cnt(fall_cnt[`DIPC_CNT_W*gi+`DIPC_CNT_W-1:`DIPC_CNT_W*gi]),
				.total_cnt(total_cnt[`DIPC_CNT_W*gi+`DIPC_CNT_W-1:`DIPC_CNT_W*gi])
			);
		end
	endgenerate

	// Per-input counter views: input one sits in the low half of each bus.
	// Naming them once keeps the read decode free of bit positions.
	wire [`DIPC_CNT_W-1:0] i1_rise_cnt;
	wire [`DIPC_CNT_W-1:0] i1_fall_cnt;
	wire [`DIPC_CNT_W-1:0] i1_total_cnt;
	wire [`DIPC_CNT_W-1:0] i2_rise_cnt;
	wire [`DIPC_CNT_W-1:0] i2_fall_cnt;
	wire [`DIPC_CNT_W-1:0] i2_total_cnt;

	assign i1_rise_cnt = rise_cnt[`DIPC_CNT_W-1:0];
	assign i1_fall_cnt = fall_cnt[`DIPC_CNT_W-1:0];
	assign i1_total_cnt = total_cnt[`DIPC_CNT_W-1:0];
	assign i2_rise_cnt = rise_cnt[2*`DIPC_CNT_W-1:`DIPC_CNT_W];
	assign i2_fall_cnt = fall_cnt[2*`DIPC_CNT_W-1:`DIPC_CNT_W];
	assign i2_total_cnt = total_cnt[2*`DIPC_CNT_W-1:`DIPC_CNT_W];

	// ----------------------------------------------------------------
	// Position latches for input one
	// ----------------------------------------------------------------

	// Stored positions are signed; sums wrap as two's complement would.
	reg [`DIPC_POS_W-1:0] cap_pos_ff;
	reg [`DIPC_POS_W-1:0] rise_pos_ff;
	reg [`DIPC_POS_W-1:0] fall_pos_ff;
	reg [`DIPC_POS_W-1:0] snap_pos_ff;
	reg [`DIPC_POS_W-1:0] nxt_cap_pos;
	reg [`DIPC_POS_W-1:0] nxt_rise_pos;
	reg [`DIPC_POS_W-1:0] nxt_fall_pos;
	reg [`DIPC_POS_W-1:0] nxt_snap_pos;
	wire snap_read;

	// Reading the snapshot counter is what refreshes the position copy.
	assign snap_read = dipc_hit(rd_req, rd_addr, `DIPC_ADDR_I1_TOTAL_SNAP);

	// A new capture takes the live position, already in the new reference,
	// so it overrides the origin shift in the same cycle.
	always @* begin
		nxt_cap_pos = cap_pos_ff;
		nxt_rise_pos = rise_pos_ff;
		nxt_fall_pos = fall_pos_ff;
		nxt_snap_pos = snap_pos_ff;
		if (origin_shift_valid) begin
			nxt_cap_pos = cap_pos_ff + origin_shift;
			nxt_rise_pos = rise_pos_ff + origin_shift;
			nxt_fall_pos = fall_pos_ff + origin_shift;
			nxt_snap_pos = snap_pos_ff + origin_shift;
		end
		if (capture_evt[0]) begin
			nxt_cap_pos = pos_actual;
		end
		if (rise_evt[0]) begin
			nxt_rise_pos = pos_actual;
		end
		if (fall_evt[0]) begin
			nxt_fall_pos = pos_actual;
		end
		// The copy pairs with the count that this same read returns, which is the
		// registered total before this cycle's events; an origin shift in the same
		// cycle still re-references it.
		if (snap_read) begin
			if (origin_shift_valid) begin
				nxt_snap_pos = cap_pos_ff + origin_shift;
			end else begin
				nxt_snap_pos = cap_pos_ff;
			end
		end
	end

	// Position registers hold their value until a capture, an origin shift or, for the snapshot copy, a snapshot read.
	always @(posedge clock) begin
		if (rst) begin
			cap_pos_ff <= `DIPC_POS_RST;
			rise_pos_ff <= `DIPC_POS_RST;
			fall_pos_ff <= `DIPC_POS_RST;
			snap_pos_ff <= `DIPC_POS_RST;
		end else begin
			cap_pos_ff <= nxt_cap_pos;
			rise_pos_ff <= nxt_rise_pos;
			fall_pos_ff <= nxt_fall_pos;
			snap_pos_ff <= nxt_snap_pos;
		end
	end

	// ----------------------------------------------------------------
	// Capture flags word
	// ----------------------------------------------------------------

	// A flag stays set until its input is activated again; reading leaves it.
	reg [1:0] flags_ff;
	wire [1:0] nxt_flags;

	// Activation clears a flag, but a capture in the same cycle sets it again.
	genvar gf;
	generate
		for (gf = 0; gf < 2; gf = gf + 1) begin : g_flag
			assign nxt_flags[gf] = capture_evt[gf] | (flags_ff[gf] & ~activate[gf]);
		end
	endgenerate

	always @(posedge clock) begin
		if (rst) begin
			flags_ff <= 2'h0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	wire [`DIPC_POS_W-1:0] flags_word;
	// The flags word carries input one in the low bit and input two above it.
	assign flags_word = {`DIPC_CNT_PAD, `DIPC_FLAGS_PAD, flags_ff[`DIPC_FLAG_I2],
		flags_ff[`DIPC_FLAG_I1]};

	// ----------------------------------------------------------------
	// Parameter read port
	// ----------------------------------------------------------------

	reg [`DIPC_POS_W-1:0] rd_data_ff;
	reg rd_ack_ff;
	reg rd_err_ff;
	reg [`DIPC_POS_W-1:0] nxt_rd_data;

	// Counters sit in the low half with zero above; positions use all bits.
	always @* begin
		case (rd_addr)
			`DIPC_ADDR_FLAGS: nxt_rd_data = flags_word;
			`DIPC_ADDR_I1_POS: nxt_rd_data = cap_pos_ff;
			`DIPC_ADDR_I1_TOTAL: nxt_rd_data = dipc_cnt_word(i1_total_cnt);
			`DIPC_ADDR_I2_TOTAL: nxt_rd_data = dipc_cnt_word(i2_total_cnt);
			`DIPC_ADDR_I1_TOTAL_SNAP: nxt_rd_data = dipc_cnt_word(i1_total_cnt);
			`DIPC_ADDR_I1_POS_SNAP: nxt_rd_data = snap_pos_ff;
			`DIPC_ADDR_I1_RISE_POS: nxt_rd_data = rise_pos_ff;
			`DIPC_ADDR_I1_FALL_POS: nxt_rd_data = fall_pos_ff;
			`DIPC_ADDR_I1_RISE_CNT: nxt_rd_data = dipc_cnt_word(i1_rise_cnt);
			`DIPC_ADDR_I1_FALL_CNT: nxt_rd_data = dipc_cnt_word(i1_fall_cnt);
			`DIPC_ADDR_I2_RISE_CNT: nxt_rd_data = dipc_cnt_word(i2_rise_cnt);
			`DIPC_ADDR_I2_FALL_CNT: nxt_rd_data = dipc_cnt_word(i2_fall_cnt);
			default: nxt_rd_data = `DIPC_DATA_RST;
		endcase
	end

	// One answer per request, one cycle later; unmapped reads return zero.
	// Read data moves only on a request, so it stands until the next answer.
	// The error flag rides with the answer and is never raised on its own.
	always @(posedge clock) begin
		if (rst) begin
			rd_data_ff <= `DIPC_DATA_RST;
			rd_ack_ff <= 1'b0;
			rd_err_ff <= 1'b0;
		end else begin
			rd_ack_ff <= rd_req;
			rd_err_ff <= rd_req & ~dipc_is_mapped(rd_addr);
			if (rd_req) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	assign rd_ack = rd_ack_ff;
	assign rd_err = rd_err_ff;
	assign rd_data = rd_data_ff;

endmodule

// [dv/dipc_capture_properties.sv]
// Checker for the read port and counter clearing of the capture block.
`timescale 1ns/1ps
`include "dipc_consts.vh"
module dipc_capture_properties (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Observed ports.
	input wire capture_pin_one,
	input wire capture_pin_one_enable,
	input wire rd_req,
	input wire [`DIPC_ADDR_W-1:0] rd_addr,
	input wire rd_ack,
	input wire rd_err,
	input wire [`DIPC_POS_W-1:0] rd_data
);
	// ------------
	// Properties
	// ------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	ack_follows_req_a: assert property (rd_req |=> rd_ack)
		else $error("read not answered");
	ack_needs_req_a: assert property (!rd_req |=> !rd_ack)
		else $error("answer without read");
	err_unmapped_a: assert property (rd_req && rd_addr[15:8] != 8'h0a
		|=> rd_err && rd_data == 32'h0) else $error("unmapped read");
	cnt_upper_zero_a: assert property (rd_req && rd_addr inside {16'h0a10, 16'h0a12,
		16'h0a2e, 16'h0a56, 16'h0a58, 16'h0a5a, 16'h0a5c}
		|=> !rd_err && rd_data[31:16] == 16'h0) else $error("counter read");
	flags_bits_a: assert property (rd_req && rd_addr == 16'h0a02
		|=> !rd_err && rd_data[31:2] == 30'h0) else $error("flags read");
	pos_mapped_a: assert property (rd_req && rd_addr inside {16'h0a0c, 16'h0a30,
		16'h0a4a, 16'h0a4c} |=> !rd_err) else $error("position read");
	data_holds_a: assert property (!rd_ack |-> $stable(rd_data))
		else $error("read data moved");
	// The pin must be quiet around activation, or a late edge would count legally.
	activate_clears_a: assert property ($stable(capture_pin_one)[*3] ##1
		($rose(capture_pin_one_enable) && $stable(capture_pin_one)) ##1 (rd_req
		&& rd_addr == 16'h0a10 && $stable(capture_pin_one)) |=> rd_data == 32'h0)
		else $error("total not cleared");
endmodule
bind dipc_capture dipc_capture_properties props_u (.clock(clock), .rst(rst),
	.capture_pin_one(capture_pin_one), .capture_pin_one_enable(capture_pin_one_enable), .rd_req(rd_req),
	.rd_addr(rd_addr), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data));

// [dv/dipc_feedback_model.sv]
// Position feedback model: actual position and origin re-referencing.
`timescale 1ns/1ps
module dipc_feedback_model (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Motion and position-set requests.
	input wire [31:0] velocity,
	input wire set_req,
	input wire [31:0] set_value,
	// Feedback to the capture block.
	output reg [31:0] pos_actual,
	output reg origin_shift_valid,
	output reg [31:0] origin_shift
);
	// ------------
	// Integrator
	// ------------
	// A set jumps the position; the delta lets stored captures follow the origin.
	always @(posedge clock) begin
		if (rst) begin
			pos_actual <= 32'h0;
			origin_shift_valid <= 1'b0;
			origin_shift <= 32'h0;
		end else begin
			origin_shift_valid <= set_req;
			origin_shift <= set_value - pos_actual;
			pos_actual <= set_req ? set_value : pos_actual + velocity;
		end
	end
endmodule

// [dv/dipc_capture_test.sv]
// Self-checking bench for the dual-input position capture block.
`timescale 1ns/1ps
module dipc_capture_test;
	// ------------
	// Signals
	// ------------
	logic clock, rst, capture_pin_one, capture_pin_two, capture_pin_one_enable, capture_pin_two_enable;
	logic [1:0] capture_pin_one_edge_mode, capture_pin_two_edge_mode;
	logic [31:0] pos_actual, origin_shift, rd_data, velocity, set_value;
	logic origin_shift_valid, rd_req, rd_ack, rd_err, set_req;
	logic [15:0] rd_addr;
	int err_total, comparisons;
	// Rows: address, expected data, expected error.
	logic [48:0] rows [13] = '{
		{16'h0a02, 32'h3, 1'b0},
		{16'h0a0c, 32'h100, 1'b0},
		{16'h0a10, 32'h2, 1'b0},
		{16'h0a12, 32'h2, 1'b0},
		{16'h0a30, 32'h100, 1'b0},
		{16'h0a2e, 32'h2, 1'b0},
		{16'h0a4a, 32'hffff_ff0c, 1'b0},
		{16'h0a4c, 32'h100, 1'b0},
		{16'h0a56, 32'h1, 1'b0},
		{16'h0a58, 32'h1, 1'b0},
		{16'h0a5a, 32'h2, 1'b0},
		{16'h0a5c, 32'h1, 1'b0},
		{16'h0b00, 32'h0, 1'b1}};
	dipc_capture DUT (.clock(clock), .rst(rst), .capture_pin_one(capture_pin_one),
		.capture_pin_two(capture_pin_two), .capture_pin_one_enable(capture_pin_one_enable),
		.capture_pin_two_enable(capture_pin_two_enable), .capture_pin_one_edge_mode(capture_pin_one_edge_mode),
		.capture_pin_two_edge_mode(capture_pin_two_edge_mode), .pos_actual(pos_actual),
		.origin_shift_valid(origin_shift_valid), .origin_shift(origin_shift),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_err(rd_err),
		.rd_data(rd_data));
	dipc_feedback_model feedback_u (.clock(clock), .rst(rst), .velocity(velocity),
		.set_req(set_req), .set_value(set_value), .pos_actual(pos_actual),
		.origin_shift_valid(origin_shift_valid), .origin_shift(origin_shift));
	// ------------
	// Tasks
	// ------------
	task end_of_test();
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One read; the answer is awaited for a few cycles only, so a hang ends the run.
	task rd(input logic [15:0] a, input logic [31:0] e, input logic ee);
		int n;
		@(posedge clock);
		rd_req <= 1'b1;
		rd_addr <= a;
		@(posedge clock);
		rd_req <= 1'b0;
		n = 0;
		@(negedge clock);
		while (rd_ack !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		chk($sformatf("ack %h", a), {31'h0, rd_ack}, 32'h1);
		chk($sformatf("data %h", a), rd_data, e);
		chk($sformatf("err %h", a), {31'h0, rd_err}, {31'h0, ee});
		// A missing answer has already been counted by the checks above.
		if (rd_ack !== 1'b1) end_of_test();
	endtask
	// Pin levels change, then the synchroniser is given time to settle.
	task pins(input logic a, input logic b);
		@(posedge clock);
		capture_pin_one <= a;
		capture_pin_two <= b;
		repeat (5) @(posedge clock);
	endtask
	task move(input logic [31:0] d);
		@(posedge clock);
		velocity <= d;
		@(posedge clock);
		velocity <= 32'h0;
	endtask
	// ------------
	// Sequence
	// ------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		{rst, capture_pin_one, capture_pin_two, capture_pin_one_enable, capture_pin_two_enable} = 5'h10;
		{capture_pin_one_edge_mode, capture_pin_two_edge_mode} = 4'h8;
		{rd_req, rd_addr, velocity, set_req, set_value} = 82'h0;
		err_total = 0;
		comparisons = 0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		capture_pin_one_enable <= 1'b1;
		capture_pin_two_enable <= 1'b1;
		move(32'd1000);
		pins(1'b1, 1'b1);
		move(32'd500);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		rd(16'h0a2e, 32'h2, 1'b0);
		@(posedge clock);
		set_req <= 1'b1;
		set_value <= 32'h100;
		@(posedge clock);
		set_req <= 1'b0;
		foreach (rows[i]) rd(rows[i][48:33], rows[i][32:1], rows[i][0]);
		// Re-activation clears; the copy stays locked until the trigger is read.
		@(posedge clock);
		capture_pin_one_enable <= 1'b0;
		@(posedge clock);
		capture_pin_one_enable <= 1'b1;
		capture_pin_one_edge_mode <= 2'h3;
		capture_pin_two_edge_mode <= 2'h1;
		rd(16'h0a10, 32'h0, 1'b0);
		rd(16'h0a02, 32'h2, 1'b0);
		move(32'd4);
		pins(1'b1, 1'b1);
		rd(16'h0a30, 32'h100, 1'b0);
		rd(16'h0a2e, 32'h1, 1'b0);
		rd(16'h0a30, 32'h104, 1'b0);
		rd(16'h0a56, 32'h1, 1'b0);
		pins(1'b0, 1'b0);
		// Input two now totals falls only; input one totals rises only.
		rd(16'h0a12, 32'h3, 1'b0);
		rd(16'h0a10, 32'h1, 1'b0);
		rd(16'h0a4c, 32'h104, 1'b0);
		// A second reset returns every stored value to zero.
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(16'h0a4a, 32'h0, 1'b0);
		rd(16'h0a5a, 32'h0, 1'b0);
		end_of_test();
	end
endmodule
